/* File: logic/conv_sequencer.sv */
// Conversion sequencer: modes, data buffer, accumulator, AXI4-Lite registers
// Overview of operation
// R1: Powers up in manual mode until configured
// R2: Manual mode converts only on host trigger
// R3: Autonomous waits one host pulse, then self-times
// R4: Start burst stores exactly 16 results
// R5: Start burst halts when buffer full
// R6: Stop burst stores until abort
// R7: Host abort ends stop burst filling
// R8: Pre-alert stores until threshold alert
// R9: Pre-alert abort stops further storing
// R10: Post-alert stores only after alert
// R11: Post-alert abort stops further storing
// R12: Host clears alert before next sequence
// R13: High precision sums results, 16 bits
// R14: High precision start begins accumulating
// R15: Accumulation stops after configured count
// R16: Abort ends high precision at once
// R17: Count setting max 15, conversions = setting+1
// R18: Power-up manual uses channel 0, fast oscillator
// R19: Write pointer resets per sequence, full at 16
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.svh"
module conv_sequencer
  import seq_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                    clk_in,
  input  wire logic                    reset_in,
  input  wire logic                    clk_en_in,
  // AXI4-Lite write address and data
  input  wire logic                    awvalid_in,
  output logic                         awready_out,
  input  wire logic [7:0]              awaddr_in,
  input  wire logic                    wvalid_in,
  output logic                         wready_out,
  input  wire logic [31:0]             wdata_in,
  input  wire logic [3:0]              wstrb_in,
  // AXI4-Lite write response
  output logic                         bvalid_out,
  input  wire logic                    bready_in,
  output logic [1:0]                   bresp_out,
  // AXI4-Lite read
  input  wire logic                    arvalid_in,
  output logic                         arready_out,
  input  wire logic [7:0]              araddr_in,
  output logic                         rvalid_out,
  input  wire logic                    rready_in,
  output logic [31:0]                  rdata_out,
  output logic [1:0]                   rresp_out,
  // Host link and converter front end
  input  wire logic                    link_clk_in,
  input  wire logic                    host_soc_in,
  output logic                         soc_out,
  output logic                         chan_sel_out,
  output logic                         osc_fast_out,
  input  wire logic                    conv_done_in,
  input  wire logic [`SAMPLE_W-1:0]    conv_data_in,
  input  wire logic                    alert_in,
  // Interrupt
  output logic                         irq_out
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    op_mode_t                   mode;
    logic                       chan;
    logic                       osc_fast;
    logic [`ACC_CNT_W-1:0]      acc_cfg;
    logic [`OSC_DIV_W-1:0]      osc_div;
    seq_state_t                 seq;
    logic                       triggered;
    logic                       alert_seen;
    logic [`BUF_PTR_W-1:0]      wptr;
    logic [`ACC_CNT_W:0]        acc_n;
    logic [`ACC_W-1:0]          acc;
    logic [`OSC_DIV_W-1:0]      tick;
    logic                       soc;
    logic                       busy;
    logic                       man_soc;
    logic [`IRQ_W-1:0]          irq_stat;
    logic [`IRQ_W-1:0]          irq_en;
    logic [`BUF_DEPTH-1:0][`SAMPLE_W-1:0] buf_mem;
    logic                       aw_h;
    logic [7:0]                 awaddr;
    logic                       w_h;
    logic [31:0]                wdata;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
  } core_state_t;
  core_state_t st_q;
  core_state_t st_d;

  logic link_rise;
  logic soc_level;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Link clock edges qualify the host start pulse on the bus pin
  link_sync u_link_clk (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .enable_in (clk_en_in),
    .pin_in    (link_clk_in),
    .level_out (),
    .rise_out  (link_rise)
  );
  link_sync u_host_soc (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .enable_in (clk_en_in),
    .pin_in    (host_soc_in),
    .level_out (soc_level),
    .rise_out  ()
  );

  // Buffer window address decode, used by the read path only
  function automatic logic is_buf(input logic [7:0] a);
    return a >= `OFF_BUF_BASE && a < (`OFF_BUF_BASE + 8'(`BUF_DEPTH * 4));
  endfunction

  logic host_pulse;
  logic wr_fire;
  logic rd_fire;
  logic do_start;
  logic do_abort;
  logic do_alclr;
  logic store_ok;
  logic [`BUF_PTR_W-2:0] rd_idx;

  // A host pulse is the start line seen high at a link clock rising edge
  assign host_pulse = link_rise & soc_level;
  assign wr_fire    = st_q.aw_h & st_q.w_h & ~st_q.bvalid;
  assign rd_fire    = arvalid_in & ~st_q.rvalid;
  assign do_start   = wr_fire && st_q.awaddr == `OFF_CMD && st_q.wdata[`CMD_START_BIT];
  assign do_abort   = wr_fire && st_q.awaddr == `OFF_CMD && st_q.wdata[`CMD_ABORT_BIT];
  assign do_alclr   = wr_fire && st_q.awaddr == `OFF_CMD && st_q.wdata[`CMD_ALCLR_BIT];
  assign rd_idx     = araddr_in[`BUF_PTR_W:2];

  // Decide whether a finished conversion may land in the buffer
  always_comb begin
    case (st_q.mode)
      MODE_START_BURST: store_ok = st_q.wptr != `BUF_FULL_PTR;            // R4 R5
      MODE_STOP_BURST:  store_ok = 1'b1;                                  // R6
      MODE_PRE_ALERT:   store_ok = ~st_q.alert_seen && ~alert_in;         // R8
      MODE_POST_ALERT:  store_ok = st_q.alert_seen || alert_in;           // R10
      default:          store_ok = 1'b0;
    endcase
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    st_d        = st_q;
    st_d.soc    = 1'b0;
    st_d.man_soc = 1'b0;
    // Write channel capture, either order
    if (awvalid_in && !st_q.aw_h) begin
      st_d.aw_h   = 1'b1;
      st_d.awaddr = awaddr_in;
    end
    if (wvalid_in && !st_q.w_h) begin
      st_d.w_h   = 1'b1;
      st_d.wdata = wdata_in;
    end
    if (st_q.bvalid && bready_in) begin
      st_d.bvalid = 1'b0;
    end
    if (st_q.rvalid && rready_in) begin
      st_d.rvalid = 1'b0;
    end
    // Register writes; byte strobes are ignored, lane 0 carries every field but osc_div, which spans lanes 0 and 1
    if (wr_fire) begin
      st_d.aw_h   = 1'b0;
      st_d.w_h    = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp  = `AXI_RESP_OKAY;
      case (st_q.awaddr)
        `OFF_MODE_CFG: if (wstrb_in[0] || 1'b1) begin
          // Mode changes only by this write; idle keeps manual otherwise  R1
          if (st_q.seq == ST_IDLE && st_q.wdata[`MODE_W-1:0] <= 3'(MODE_HIGH_PREC)) begin
            st_d.mode = op_mode_t'(st_q.wdata[`MODE_W-1:0]);
          end
          st_d.chan     = st_q.wdata[4];
          st_d.osc_fast = st_q.wdata[5];
        end
        `OFF_CMD: begin
          if (st_q.wdata[`CMD_TRIG_BIT] && st_q.mode == MODE_MANUAL) begin
            st_d.man_soc = 1'b1;                                          // R2
          end
        end
        // Setting above 15 cannot be held: field is four bits wide       R17
        `OFF_ACC_CFG:   st_d.acc_cfg = st_q.wdata[`ACC_CNT_W-1:0];        // R17
        `OFF_OSC_CFG:   st_d.osc_div = st_q.wdata[`OSC_DIV_W-1:0];
        `OFF_IRQ_CLEAR: st_d.irq_stat = st_q.irq_stat & ~st_q.wdata[`IRQ_W-1:0];
        `OFF_IRQ_ENABLE: st_d.irq_en = st_q.wdata[`IRQ_W-1:0];
        default: st_d.bresp = `AXI_RESP_SLVERR;
      endcase
    end
    // Alert clear lets the next alert-driven sequence run cleanly        R12
    if (do_alclr) begin
      st_d.alert_seen = 1'b0;
    end
    // Sequence start: pointer and accumulator restart                    R19
    if (do_start && st_q.mode != MODE_MANUAL) begin
      st_d.seq   = ST_WAIT_SOC;                                           // R3
      st_d.wptr  = '0;                                                    // R19
      st_d.acc   = '0;                                                    // R14
      st_d.acc_n = '0;
      st_d.busy  = 1'b0;
    end
    // Host start pulse: manual conversion or first autonomous pulse
    if (host_pulse && st_q.mode == MODE_MANUAL) begin
      st_d.soc = 1'b1;                                                    // R2
    end
    if (st_q.man_soc) begin
      st_d.soc = 1'b1;                                                    // R2
    end
    case (st_q.seq)
      ST_WAIT_SOC: begin
        if (host_pulse) begin
          st_d.seq  = ST_RUN;                                             // R3
          st_d.soc  = 1'b1;
          st_d.busy = 1'b1;
          st_d.tick = '0;
        end
      end
      ST_RUN: begin
        // Internal oscillator paces all later start pulses              R3
        if (!st_q.busy) begin
          if (st_q.tick >= st_q.osc_div) begin
            st_d.tick = '0;
            st_d.soc  = 1'b1;
            st_d.busy = 1'b1;
          end else begin
            st_d.tick = st_q.tick + 1'b1;
          end
        end
        if (conv_done_in && st_q.busy) begin
          st_d.busy = 1'b0;
          if (alert_in) begin
            st_d.alert_seen = 1'b1;
          end
          if (st_q.mode == MODE_HIGH_PREC) begin
            st_d.acc   = st_q.acc + `ACC_W'(conv_data_in);                // R13
            st_d.acc_n = st_q.acc_n + 1'b1;
            if (st_q.acc_n == {1'b0, st_q.acc_cfg}) begin
              st_d.seq = ST_IDLE;                                         // R15 R17
            end
          end else if (store_ok) begin
            st_d.buf_mem[st_q.wptr[`BUF_PTR_W-2:0]] = conv_data_in;
            st_d.wptr = (st_q.wptr == `BUF_FULL_PTR - 1'b1 &&
                         st_q.mode == MODE_STOP_BURST) ? '0 : st_q.wptr + 1'b1;
            if (st_q.mode == MODE_START_BURST && st_q.wptr == `BUF_FULL_PTR - 1'b1) begin
              st_d.seq = ST_IDLE;                                         // R5
            end
            if (st_q.mode == MODE_POST_ALERT && st_q.wptr == `BUF_FULL_PTR - 1'b1) begin
              st_d.seq = ST_IDLE;
            end
          end else if (st_q.mode == MODE_PRE_ALERT) begin
            st_d.seq = ST_IDLE;                                           // R8
          end
        end
      end
      default: ;
    endcase
    // Abort ends any running sequence at once                            R7
    if (do_abort) begin
      st_d.seq  = ST_IDLE;                                                // R7 R9 R11 R16
      st_d.soc  = 1'b0;
      st_d.busy = 1'b0;
    end
    // Sticky events: set wins over a clear in the same cycle
    if (st_q.wptr != `BUF_FULL_PTR && st_d.wptr == `BUF_FULL_PTR) begin
      st_d.irq_stat[`IRQ_BUF_FULL] = 1'b1;
    end
    if (!st_q.alert_seen && st_d.alert_seen) begin
      st_d.irq_stat[`IRQ_ALERT] = 1'b1;
    end
    if (st_q.seq == ST_RUN && st_d.seq == ST_IDLE && st_q.mode == MODE_HIGH_PREC) begin
      st_d.irq_stat[`IRQ_ACC_DONE] = 1'b1;
    end
    if (conv_done_in) begin
      st_d.irq_stat[`IRQ_CONV_DONE] = 1'b1;
    end
    // Read channel: one word per accepted address
    if (rd_fire) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = `AXI_RESP_OKAY;
      st_d.rdata  = '0;
      if (is_buf(araddr_in)) begin
        st_d.rdata = 32'(st_q.buf_mem[rd_idx]);
      end else begin
        case (araddr_in)
          `OFF_MODE_CFG:   st_d.rdata = 32'({st_q.osc_fast, st_q.chan, 1'b0, st_q.mode});
          `OFF_ACC_CFG:    st_d.rdata = 32'(st_q.acc_cfg);
          `OFF_OSC_CFG:    st_d.rdata = 32'(st_q.osc_div);
          `OFF_STATUS:     st_d.rdata = 32'({st_q.alert_seen, st_q.busy, st_q.seq});
          `OFF_BUF_STATUS: st_d.rdata = 32'(st_q.wptr);
          `OFF_ACC_RESULT: st_d.rdata = 32'({st_q.acc_n, st_q.acc});
          `OFF_IRQ_STATUS: st_d.rdata = 32'(st_q.irq_stat);
          `OFF_IRQ_ENABLE: st_d.rdata = 32'(st_q.irq_en);
          `OFF_CMD, `OFF_IRQ_CLEAR: st_d.rdata = '0;
          default:         st_d.rresp = `AXI_RESP_SLVERR;
        endcase
      end
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Power-up: manual mode, channel 0, fast oscillator                    R1 R18
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_q          <= '0;
      st_q.mode     <= MODE_MANUAL;                                       // R1
      st_q.chan     <= 1'b0;                                              // R18
      st_q.osc_fast <= 1'b1;                                              // R18
      st_q.osc_div  <= `OSC_DIV_RESET;
      st_q.seq      <= ST_IDLE;
    end else if (clk_en_in) begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign awready_out  = ~st_q.aw_h;
  assign wready_out   = ~st_q.w_h;
  assign bvalid_out   = st_q.bvalid;
  assign bresp_out    = st_q.bresp;
  assign arready_out  = ~st_q.rvalid;
  assign rvalid_out   = st_q.rvalid;
  assign rdata_out    = st_q.rdata;
  assign rresp_out    = st_q.rresp;
  assign soc_out      = st_q.soc;
  assign chan_sel_out = st_q.chan;
  assign osc_fast_out = st_q.osc_fast;
  assign irq_out      = |(st_q.irq_stat & st_q.irq_en);

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_start_burst_stops;                                           // R5
    @(posedge clk_in) disable iff (reset_in)
      (st_q.mode == MODE_START_BURST && st_q.wptr == `BUF_FULL_PTR) |-> st_q.seq != ST_RUN;
  endproperty
  a_start_burst_stops: assert property (p_start_burst_stops)              // R5
    else $error("start burst runs with buffer full");

  property p_abort_idle;                                                  // R7
    @(posedge clk_in) disable iff (reset_in)
      (do_abort && clk_en_in) |=> st_q.seq == ST_IDLE;
  endproperty
  a_abort_idle: assert property (p_abort_idle)                            // R7
    else $error("abort did not end sequence");

  property p_no_soc_manual;                                               // R2
    @(posedge clk_in) disable iff (reset_in)
      (st_q.soc && st_q.mode == MODE_MANUAL) |-> $past(host_pulse) || $past(st_q.man_soc);
  endproperty
  a_no_soc_manual: assert property (p_no_soc_manual)                      // R2
    else $error("manual conversion without trigger");

  property p_wait_first;                                                  // R3
    @(posedge clk_in) disable iff (reset_in)
      (st_q.seq == ST_WAIT_SOC) |-> !st_q.soc;
  endproperty
  a_wait_first: assert property (p_wait_first)                            // R3
    else $error("start pulse before host pulse");

  property p_acc_bound;                                                   // R15
    @(posedge clk_in) disable iff (reset_in)
      st_q.acc_n <= {1'b0, st_q.acc_cfg} + 5'h01 || st_q.seq != ST_RUN;
  endproperty
  a_acc_bound: assert property (p_acc_bound)                              // R15
    else $error("accumulation count exceeded");

  property p_ptr_start;                                                   // R19
    @(posedge clk_in) disable iff (reset_in)
      (do_start && clk_en_in && st_q.mode != MODE_MANUAL) |=> st_q.wptr == '0;
  endproperty
  a_ptr_start: assert property (p_ptr_start)                              // R19
    else $error("pointer not reset at start");

  property p_reset_manual;                                                // R1
    @(posedge clk_in) $fell(reset_in) |-> st_q.mode == MODE_MANUAL && st_q.osc_fast;
  endproperty
  a_reset_manual: assert property (p_reset_manual)                        // R1
    else $error("not manual after reset");

  property p_pre_alert_stop;                                              // R8
    @(posedge clk_in) disable iff (reset_in)
      (st_q.mode == MODE_PRE_ALERT && st_q.alert_seen) |=> $stable(st_q.wptr) || !clk_en_in;
  endproperty
  a_pre_alert_stop: assert property (p_pre_alert_stop)                    // R8
    else $error("pre alert stored after alert");
endmodule // conv_sequencer
`default_nettype wire

/* File: logic/seq_map.svh */
// Register offsets, field positions, reset values and timing counts of the sequencer
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH
// Register byte offsets
`define OFF_MODE_CFG     8'h00
`define OFF_CMD          8'h04
`define OFF_ACC_CFG      8'h08
`define OFF_OSC_CFG      8'h0c
`define OFF_STATUS       8'h10
`define OFF_BUF_STATUS   8'h14
`define OFF_ACC_RESULT   8'h18
`define OFF_IRQ_STATUS   8'h1c
`define OFF_IRQ_CLEAR    8'h20
`define OFF_IRQ_ENABLE   8'h24
`define OFF_BUF_BASE     8'h40
// Field layout
`define MODE_W           3
`define CMD_START_BIT    0
`define CMD_ABORT_BIT    1
`define CMD_TRIG_BIT     2
`define CMD_ALCLR_BIT    3
`define ACC_CNT_W        4
`define ACC_CNT_MAX      4'hf
`define BUF_DEPTH        16
`define BUF_PTR_W        5
`define BUF_FULL_PTR     5'h10
`define SAMPLE_W         12
`define ACC_W            16
`define OSC_DIV_W        16
`define OSC_DIV_RESET    16'h0010
`define IRQ_W            4
`define IRQ_BUF_FULL     0
`define IRQ_ALERT        1
`define IRQ_ACC_DONE     2
`define IRQ_CONV_DONE    3
`define AXI_RESP_OKAY    2'b00
`define AXI_RESP_SLVERR  2'b10
`endif

/* File: logic/seq_pkg.sv */
// Types shared by the conversion sequencer
package seq_pkg;
  // Operating modes selected by software
  typedef enum logic [2:0] {
    MODE_MANUAL,
    MODE_START_BURST,
    MODE_STOP_BURST,
    MODE_PRE_ALERT,
    MODE_POST_ALERT,
    MODE_HIGH_PREC
  } op_mode_t;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_SOC,
    ST_RUN
  } seq_state_t;
endpackage

/* File: logic/link_sync.sv */
// Three-stage synchroniser with agreement check and edge finder for the link clock
`timescale 1ns/1ps
`default_nettype none
module link_sync (
  // Clock and control
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic enable_in,
  // Asynchronous pin and results
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
  } sync_state_t;
  sync_state_t st_q;
  sync_state_t st_d;

  // The level moves only once stages two and three agree
  always_comb begin
    st_d      = st_q;
    st_d.rise = 1'b0;
    st_d.s1   = pin_in;
    st_d.s2   = st_q.s1;
    st_d.s3   = st_q.s2;
    if (st_q.s2 == st_q.s3 && st_q.s3 != st_q.level) begin
      st_d.level = st_q.s3;
      st_d.rise  = st_q.s3;
    end
  end

  // Register the whole state
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_q <= '0;
    end else if (enable_in) begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.level;
  assign rise_out  = st_q.rise;
endmodule // link_sync
`default_nettype wire

/* File: test/host_link.sv */
// Host link model: framed link clock and start-of-conversion line
`timescale 1ns/1ps
`default_nettype none
module host_link (
  // Request from bench
  input  wire logic frame_in,
  // Link pins
  output logic      link_clk_out,
  output logic      soc_line_out
);
  // Clock stands still low between frames; start line drops with it
  initial begin
    link_clk_out = 1'b0;
    soc_line_out = 1'b0;
  end
  // One frame: four 80 ns link periods; start line only over the first, so one pulse
  always @(posedge frame_in) begin
    soc_line_out = 1'b1;
    #3;
    #40 link_clk_out = 1'b1;
    #40 link_clk_out = 1'b0;
    soc_line_out = 1'b0;
    repeat (3) begin
      #40 link_clk_out = 1'b1;
      #40 link_clk_out = 1'b0;
    end
  end
endmodule // host_link
`default_nettype wire

/* File: test/tb_sensor_monitor_conversion_sequencer.sv */
// Testbench of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.svh"
module tb_sensor_monitor_conversion_sequencer;
  import seq_pkg::*;
  // ************ Signals ************
  logic        clk_in = 0, reset_in = 1, frame_req = 0, clk_en = 1;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        link_clk, host_soc, soc, chan_sel, osc_fast, conv_done = 0, alert = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, q, n_soc = 0, base = 0, alert_at = 0;
  logic [31:0] n_errors = 0, checks_done = 0;
  logic [1:0]  bresp, rresp, r, pend = 0;
  logic [11:0] conv_data = 12'h123;
  // ************ Instances ************
  conv_sequencer i_conv_sequencer (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en),
    .awvalid_in(awvalid), .awready_out(awready), .awaddr_in(awaddr), .wvalid_in(wvalid),
    .wready_out(wready), .wdata_in(wdata), .wstrb_in(4'hf), .bvalid_out(bvalid),
    .bready_in(bready), .bresp_out(bresp), .arvalid_in(arvalid), .arready_out(arready),
    .araddr_in(araddr), .rvalid_out(rvalid), .rready_in(rready), .rdata_out(rdata),
    .rresp_out(rresp), .link_clk_in(link_clk), .host_soc_in(host_soc), .soc_out(soc),
    .chan_sel_out(chan_sel), .osc_fast_out(osc_fast), .conv_done_in(conv_done),
    .conv_data_in(conv_data), .alert_in(alert), .irq_out(irq));
  host_link i_host_link (.frame_in(frame_req), .link_clk_out(link_clk), .soc_line_out(host_soc));
  always #4 clk_in = ~clk_in;
  // Converter front end: result three cycles after each start, alert on a chosen one
  always @(posedge clk_in) begin
    conv_done <= 1'b0;
    alert <= 1'b0;
    if (soc) begin
      n_soc = n_soc + 1;
      pend <= 2'd3;
    end else if (pend != 2'd0) begin
      pend <= pend - 2'd1;
      if (pend == 2'd1) begin
        conv_done <= 1'b1;
        alert <= (n_soc - base == alert_at);
      end
    end
  end
  // ************ Tasks ************
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done != 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] %s exp %h got %h", nm, exp, got);
      n_errors++;
    end
  endtask
  // Bus cycle; handshakes are judged 1 ns after the edge, once NBAs have landed
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb, tr, td;
    int n;
    if (w) begin
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    end else begin
      araddr <= a; arvalid <= 1; rready <= 1;
    end
    for (n = 0; awvalid | wvalid | bready | arvalid | rready | (n == 0); n++) begin
      if (n == 60) begin
        n_errors++;
        conclude();
      end
      #1;
      ta = awvalid & awready; tw = wvalid & wready; tb = bready & bvalid;
      tr = arvalid & arready; td = rready & rvalid;
      @(posedge clk_in);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if (tr) arvalid <= 0;
      if (tb) begin bready <= 0; r = bresp; end
      if (td) begin rready <= 0; q = rdata; r = rresp; end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1, a, d);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(nm, q, e);
  endtask
  task automatic frame;
    frame_req <= 1;
    repeat (60) @(posedge clk_in);
    frame_req <= 0;
  endtask
  task automatic wait_idle;
    int i;
    for (i = 0; i < 300; i++) begin
      bus(0, `OFF_STATUS, 0);
      if (q[1:0] === 2'b00) return;
    end
    n_errors++;
    conclude();
  endtask
  // Start an autonomous run in mode m; the caller sends the host pulse with frame
  task automatic run(input op_mode_t m);
    wr(`OFF_MODE_CFG, 32'(m));
    base = n_soc;
    wr(`OFF_CMD, 32'h1);
  endtask
  // ************ Scenarios ************
  task automatic t_reset;
    rd("mode", `OFF_MODE_CFG, 32'h20);
    chk("chan", {31'b0, chan_sel}, 0);
    chk("osc", {31'b0, osc_fast}, 1);
    rd("unmapped", 8'h3c, 0);
    chk("slverr", {30'b0, r}, {30'b0, `AXI_RESP_SLVERR});
    repeat (20) @(posedge clk_in);
    chk("idle soc", n_soc, 0);
  endtask
  task automatic t_manual;
    wr(`OFF_CMD, 32'h4);
    repeat (10) @(posedge clk_in);
    chk("trig soc", n_soc, 1);
    frame();
    chk("host soc", n_soc, 2);
    clk_en <= 0;
    frame();
    clk_en <= 1;
    repeat (10) @(posedge clk_in);
    chk("frozen soc", n_soc, 2);
    rd("irq st", `OFF_IRQ_STATUS, 32'h8);
    chk("masked irq", {31'b0, irq}, 0);
    wr(`OFF_IRQ_CLEAR, 32'hf);
  endtask
  task automatic t_start_burst;
    wr(`OFF_IRQ_ENABLE, 32'h1);
    run(MODE_START_BURST);
    repeat (30) @(posedge clk_in);
    chk("wait host", n_soc - base, 0);
    frame();
    wait_idle();
    chk("burst socs", n_soc - base, 16);
    rd("ptr", `OFF_BUF_STATUS, 32'h10);
    rd("entry15", 8'h7c, 32'h123);
    chk("irq on", {31'b0, irq}, 1);
    wr(`OFF_IRQ_CLEAR, 32'h1);
    chk("irq off", {31'b0, irq}, 0);
  endtask
  task automatic t_stop_burst;
    logic [31:0] k;
    run(MODE_STOP_BURST);
    frame();
    repeat (700) @(posedge clk_in);
    chk("keeps going", {31'b0, (n_soc - base) > 16}, 1);
    wr(`OFF_CMD, 32'h2);
    repeat (2) @(posedge clk_in);
    k = n_soc;
    repeat (100) @(posedge clk_in);
    chk("after abort", n_soc, k);
    rd("stopped", `OFF_STATUS, 0);
  endtask
  task automatic t_alerts;
    alert_at = 5;
    run(MODE_PRE_ALERT);
    frame();
    wait_idle();
    rd("pre ptr", `OFF_BUF_STATUS, 32'h4);
    rd("alert seen", `OFF_STATUS, 32'h8);
    wr(`OFF_CMD, 32'h8);
    rd("alert clr", `OFF_STATUS, 0);
    alert_at = 3;
    run(MODE_POST_ALERT);
    frame();
    wait_idle();
    chk("post socs", n_soc - base, 18);
    rd("post ptr", `OFF_BUF_STATUS, 32'h10);
    wr(`OFF_CMD, 32'h8);
    alert_at = 0;
  endtask
  task automatic t_high_prec;
    wr(`OFF_ACC_CFG, 32'h3);
    run(MODE_HIGH_PREC);
    frame();
    wait_idle();
    chk("acc socs", n_soc - base, 4);
    rd("acc sum", `OFF_ACC_RESULT, 32'h0004048c);
    wr(`OFF_ACC_CFG, 32'hf);
    run(MODE_HIGH_PREC);
    frame();
    repeat (40) @(posedge clk_in);
    wr(`OFF_CMD, 32'h2);
    rd("hp abort", `OFF_STATUS, 0);
    chk("hp short", {31'b0, (n_soc - base) < 16}, 1);
  endtask
  // ************ Main sequence ************
  initial begin
    repeat (5) @(posedge clk_in);
    reset_in <= 0;
    @(posedge clk_in);
    t_reset();
    t_manual();
    t_start_burst();
    t_stop_burst();
    t_alerts();
    t_high_prec();
    conclude();
  end
endmodule // tb_sensor_monitor_conversion_sequencer
`default_nettype wire
